// ### core/alc_gain_limiter.sv
/*
 * PGA gain control loop: stereo peak limiter or level control on the
 * right, left or both channels, with attack/decay ramps, transient
 * window and optional zero-cross gain updates.
 * Assumes samples, static gains and the control write port all run on
 * clk; the serial control interface decodes into reg_wr/reg_addr.
 */
// Functional notes
// - Loop drives PGA gain only while enable bit 8 is set; off at reset.
// - Function select: 00 limiter, 01 right, 10 left, 11 both.
// - Limiter ramps gain down while peaks exceed the threshold.
// - Limiter ramps back toward static gain, never above it.
// - Limiter uses larger peak of both channels, same change on both.
// - Level control steers gain so peaks sit at the target.
// - Single-channel level control leaves the other PGA at static gain.
// - Threshold code 0..15 is -16..-1 dBFS; reset code -5 dBFS.
// - Level control treats -1 and -2 dB targets as -3 dB.
// - Decay sets ramp-up: 90% range for level control, 6 dB limiter.
// - Level control decay doubles per code from 33.6 ms, saturating at 10.
// - Limiter decay 1.2 ms doubling per code, up to 1.2288 s.
// - Attack sets ramp-down: 90% range for level control, 6 dB limiter.
// - Level control attack 8.4 ms doubling, saturating at code 10.
// - Limiter attack 250 us doubling, saturating at code 10.
// - Ramp runs at fixed rate so small changes finish sooner.
// - Limiter ignores over-threshold peaks shorter than the window.
// - Window code 0 off, 1 is 62.5 us, doubling to 4 ms; reset 2.
// - Zero-cross bit makes level control apply gain at zero crossings.
// - Loop gain spans +24 dB down to -21 dB in 0.5 dB codes.
`timescale 1ns/10ps
module alc_gain_limiter #(
   parameter int unsigned LIM_ATK_BASE = alc_pkg::LIM_ATK_CYC,
   parameter int unsigned ALC_ATK_BASE = alc_pkg::ALC_ATK_CYC,
   parameter int unsigned LIM_DCY_BASE = alc_pkg::LIM_DCY_CYC,
   parameter int unsigned ALC_DCY_BASE = alc_pkg::ALC_DCY_CYC,
   parameter int unsigned WIN_BASE = alc_pkg::WIN_BASE_CYC,
   parameter int TW = 24
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Control register port
   input wire logic reg_wr,
   input wire logic [6:0] reg_addr,
   input wire logic [8:0] reg_wdata,
   output logic [8:0] reg_rdata,
   // ADC samples
   input wire logic sample_valid,
   input wire logic [23:0] sample_left,
   input wire logic [23:0] sample_right,
   // Static gains from the per-channel gain registers
   input wire logic [7:0] static_gain_left,
   input wire logic [7:0] static_gain_right,
   // PGA gain codes
   output logic [7:0] pga_gain_left,
   output logic [7:0] pga_gain_right
);

   typedef struct packed {
      logic [8:0] cfg_one;
      logic [8:0] cfg_two;
      logic [8:0] ramp_times;
      logic [8:0] window_cfg;
      logic [8:0] rdata;
      logic [6:0] atten;
      logic [7:0] loop_gain;
      logic [7:0] applied_gain;
      logic [TW-1:0] win_cnt;
      logic [7:0] out_l;
      logic [7:0] out_r;
   } alc_state_t;

   alc_state_t st_reg;
   alc_state_t st_next;

   // Decoded fields
   logic gain_loop_enable;
   logic loop_zero_cross_enable;
   alc_pkg::alc_func_t gain_loop_function_select;
   logic [3:0] threshold_target_level;
   logic [3:0] ramp_down_time;
   logic [3:0] ramp_up_time;
   logic [2:0] transient_window_length;
   logic [3:0] eff_thresh;
   logic is_limiter;

   // Compare results and ramp control
   logic above_l;
   logic above_r;
   logic zc_l;
   logic zc_r;
   logic over;
   logic zc_evt;
   logic [3:0] atk_sh;
   logic [3:0] dcy_sh;
   logic [TW-1:0] atk_interval;
   logic [TW-1:0] dcy_interval;
   logic [TW-1:0] win_len;
   logic win_passed;
   logic atk_run;
   logic dcy_run;
   logic atk_tick;
   logic dcy_tick;

   assign gain_loop_enable =
      st_reg.cfg_two[alc_pkg::LOOP_ENABLE_BIT];
   assign loop_zero_cross_enable =
      st_reg.cfg_two[alc_pkg::ZERO_CROSS_BIT];
   assign gain_loop_function_select = alc_pkg::alc_func_t'(
      st_reg.cfg_one[alc_pkg::FUNC_SEL_LSB +: 2]);
   assign threshold_target_level =
      st_reg.cfg_one[alc_pkg::THRESH_LSB +: 4];
   assign ramp_down_time = st_reg.ramp_times[alc_pkg::ATK_LSB +: 4];
   assign ramp_up_time = st_reg.ramp_times[alc_pkg::DCY_LSB +: 4];
   assign transient_window_length =
      st_reg.window_cfg[alc_pkg::WIN_LSB +: 3];
   assign is_limiter =
      gain_loop_function_select == alc_pkg::ALC_FN_LIMITER;

   // Level control clamps too-high targets to -3 dB
   always_comb begin
      eff_thresh = threshold_target_level;
      if (!is_limiter && threshold_target_level > alc_pkg::ALC_TARGET_CAP)
      begin
         eff_thresh = alc_pkg::ALC_TARGET_CAP;
      end
   end

   alc_level_cmp u_cmp_left (
      .clk(clk),
      .rst_b(rst_b),
      .sample_valid(sample_valid),
      .sample(sample_left),
      .thresh_code(eff_thresh),
      .above(above_l),
      .zero_cross(zc_l)
   );

   alc_level_cmp u_cmp_right (
      .clk(clk),
      .rst_b(rst_b),
      .sample_valid(sample_valid),
      .sample(sample_right),
      .thresh_code(eff_thresh),
      .above(above_r),
      .zero_cross(zc_r)
   );

   // Peak and zero-cross source per function
   always_comb begin
      unique case (gain_loop_function_select)
         alc_pkg::ALC_FN_RIGHT: begin
            over = above_r;
            zc_evt = zc_r;
         end
         alc_pkg::ALC_FN_LEFT: begin
            over = above_l;
            zc_evt = zc_l;
         end
         default: begin
            // Either channel over means the larger peak is over
            over = above_l | above_r;
            zc_evt = zc_l | zc_r;
         end
      endcase
   end

   // Step interval per 0.5 dB: base doubles per code, saturating
   always_comb begin
      atk_sh = (ramp_down_time > alc_pkg::CODE_SATURATE) ?
         alc_pkg::CODE_SATURATE : ramp_down_time;
      dcy_sh = (ramp_up_time > alc_pkg::CODE_SATURATE) ?
         alc_pkg::CODE_SATURATE : ramp_up_time;
      if (is_limiter) begin
         atk_interval = TW'(LIM_ATK_BASE << atk_sh);
         dcy_interval = TW'(LIM_DCY_BASE << dcy_sh);
      end else begin
         atk_interval = TW'(ALC_ATK_BASE << atk_sh);
         dcy_interval = TW'(ALC_DCY_BASE << dcy_sh);
      end
   end

   // Transient window length; code 0 disables it
   always_comb begin
      if (transient_window_length == 3'h0) begin
         win_len = '0;
      end else begin
         win_len = TW'(WIN_BASE << (transient_window_length - 3'h1));
      end
      win_passed = !is_limiter || st_reg.win_cnt >= win_len;
   end

   assign atk_run = gain_loop_enable && over && win_passed;
   assign dcy_run = gain_loop_enable && !over;

   // Fixed-rate ramps, one 0.5 dB step per tick
   alc_step_timer #(
      .W(TW)
   ) u_atk_timer (
      .clk(clk),
      .rst_b(rst_b),
      .run(atk_run),
      .interval(atk_interval),
      .tick(atk_tick)
   );

   alc_step_timer #(
      .W(TW)
   ) u_dcy_timer (
      .clk(clk),
      .rst_b(rst_b),
      .run(dcy_run),
      .interval(dcy_interval),
      .tick(dcy_tick)
   );

   // Limiter output: static gain less attenuation, floored at PGA minimum
   function automatic logic [7:0] lim_gain(input logic [7:0] stat,
                                           input logic [6:0] att);
      logic [7:0] g;
      g = stat;
      if (stat > alc_pkg::PGA_MIN) begin
         if ({1'b0, att} >= stat - alc_pkg::PGA_MIN) begin
            g = alc_pkg::PGA_MIN;
         end else begin
            g = stat - {1'b0, att};
         end
      end
      return g;
   endfunction : lim_gain

   always_comb begin
      st_next = st_reg;

      // Register writes; other fields are stored as written
      if (reg_wr) begin
         unique case (reg_addr)
            alc_pkg::ADDR_CONFIG_ONE: st_next.cfg_one = reg_wdata;
            alc_pkg::ADDR_CONFIG_TWO: st_next.cfg_two = reg_wdata;
            alc_pkg::ADDR_RAMP_TIMES: st_next.ramp_times = reg_wdata;
            alc_pkg::ADDR_WINDOW_CFG: st_next.window_cfg = reg_wdata;
            default: ;
         endcase
      end

      // Registered readback, unmapped reads as zero
      unique case (reg_addr)
         alc_pkg::ADDR_CONFIG_ONE: st_next.rdata = st_reg.cfg_one;
         alc_pkg::ADDR_CONFIG_TWO: st_next.rdata = st_reg.cfg_two;
         alc_pkg::ADDR_RAMP_TIMES: st_next.rdata = st_reg.ramp_times;
         alc_pkg::ADDR_WINDOW_CFG: st_next.rdata = st_reg.window_cfg;
         default: st_next.rdata = 9'h000;
      endcase

      // Over-threshold duration, saturating
      if (!gain_loop_enable || !over) begin
         st_next.win_cnt = '0;
      end else if (st_reg.win_cnt != {TW{1'b1}}) begin
         st_next.win_cnt = st_reg.win_cnt + TW'(1);
      end

      if (!gain_loop_enable) begin
         // Idle loop restarts from the static setting
         st_next.atten = 7'h00;
         st_next.loop_gain = (gain_loop_function_select ==
            alc_pkg::ALC_FN_RIGHT) ? static_gain_right : static_gain_left;
         st_next.applied_gain = st_next.loop_gain;
      end else if (is_limiter) begin
         st_next.loop_gain = static_gain_left;
         st_next.applied_gain = static_gain_left;
         if (atk_tick && st_reg.atten < alc_pkg::ATTEN_MAX) begin
            st_next.atten = st_reg.atten + 7'h01;
         end else if (dcy_tick && st_reg.atten != 7'h00) begin
            // Stops at zero attenuation: never above static
            st_next.atten = st_reg.atten - 7'h01;
         end
      end else begin
         st_next.atten = 7'h00;
         if (atk_tick && st_reg.loop_gain > alc_pkg::PGA_MIN) begin
            st_next.loop_gain = st_reg.loop_gain - 8'h01;
         end else if (dcy_tick && st_reg.loop_gain < alc_pkg::PGA_MAX)
         begin
            st_next.loop_gain = st_reg.loop_gain + 8'h01;
         end
         // Pending change waits for a zero crossing when asked
         if (!loop_zero_cross_enable || zc_evt) begin
            st_next.applied_gain = st_reg.loop_gain;
         end
      end

      // PGA gains per function
      if (!gain_loop_enable) begin
         st_next.out_l = static_gain_left;
         st_next.out_r = static_gain_right;
      end else begin
         unique case (gain_loop_function_select)
            alc_pkg::ALC_FN_LIMITER: begin
               // Same attenuation on both keeps the stereo image
               st_next.out_l = lim_gain(static_gain_left,
                  st_reg.atten);
               st_next.out_r = lim_gain(static_gain_right,
                  st_reg.atten);
            end
            alc_pkg::ALC_FN_RIGHT: begin
               st_next.out_l = static_gain_left;
               st_next.out_r = st_reg.applied_gain;
            end
            alc_pkg::ALC_FN_LEFT: begin
               st_next.out_l = st_reg.applied_gain;
               st_next.out_r = static_gain_right;
            end
            alc_pkg::ALC_FN_STEREO: begin
               st_next.out_l = st_reg.applied_gain;
               st_next.out_r = st_reg.applied_gain;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= '0;
         st_reg.cfg_one <= alc_pkg::RST_CONFIG_ONE;
         st_reg.cfg_two <= alc_pkg::RST_CONFIG_TWO;
         st_reg.ramp_times <= alc_pkg::RST_RAMP_TIMES;
         st_reg.window_cfg <= alc_pkg::RST_WINDOW_CFG;
         st_reg.loop_gain <= alc_pkg::PGA_MIN;
         st_reg.applied_gain <= alc_pkg::PGA_MIN;
         st_reg.out_l <= alc_pkg::PGA_MIN;
         st_reg.out_r <= alc_pkg::PGA_MIN;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata = st_reg.rdata;
   assign pga_gain_left = st_reg.out_l;
   assign pga_gain_right = st_reg.out_r;

endmodule : alc_gain_limiter

// ### core/alc_level_cmp.sv
/*
 * Per-channel peak compare and zero-cross detect on ADC samples.
 * Assumes samples are signed 24-bit and arrive on this clock.
 */
`timescale 1ns/10ps
module alc_level_cmp (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Sample stream
   input wire logic sample_valid,
   input wire logic [23:0] sample,
   // Threshold code
   input wire logic [3:0] thresh_code,
   // Results
   output logic above,
   output logic zero_cross
);

   typedef struct packed {
      logic above;
      logic sign;
      logic zc;
   } alc_cmp_st_t;

   alc_cmp_st_t st_reg;
   alc_cmp_st_t st_next;
   logic [23:0] mag;

   always_comb begin
      mag = sample[23] ? (24'h000000 - sample) : sample;
      st_next = st_reg;
      st_next.zc = 1'b0;
      if (sample_valid) begin
         st_next.above = mag > alc_pkg::THRESH_TABLE[thresh_code];
         st_next.sign = sample[23];
         st_next.zc = sample[23] != st_reg.sign;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign above = st_reg.above;
   assign zero_cross = st_reg.zc;

endmodule : alc_level_cmp

// ### core/alc_pkg.sv
/*
 * Shared constants for the PGA gain control loop: register offsets,
 * field positions, reset values, gain range and ramp timing.
 * Assumes a 25 MHz master clock and 9-bit control registers.
 */
package alc_pkg;

   // Register offsets on the control port
   localparam logic [6:0] ADDR_CONFIG_ONE = 7'h10;
   localparam logic [6:0] ADDR_CONFIG_TWO = 7'h11;
   localparam logic [6:0] ADDR_RAMP_TIMES = 7'h12;
   localparam logic [6:0] ADDR_WINDOW_CFG = 7'h14;

   // Values after reset
   localparam logic [8:0] RST_CONFIG_ONE = 9'h07b;
   localparam logic [8:0] RST_CONFIG_TWO = 9'h000;
   localparam logic [8:0] RST_RAMP_TIMES = 9'h032;
   localparam logic [8:0] RST_WINDOW_CFG = 9'h026;

   // Field positions
   localparam int LOOP_ENABLE_BIT = 8;
   localparam int ZERO_CROSS_BIT = 7;
   localparam int FUNC_SEL_LSB = 7;
   localparam int THRESH_LSB = 0;
   localparam int ATK_LSB = 0;
   localparam int DCY_LSB = 4;
   localparam int WIN_LSB = 4;

   typedef enum logic [1:0] {
      ALC_FN_LIMITER = 2'h0,
      ALC_FN_RIGHT = 2'h1,
      ALC_FN_LEFT = 2'h2,
      ALC_FN_STEREO = 2'h3
   } alc_func_t;

   // PGA codes: 0.5 dB per code, -21 dB .. +24 dB
   localparam logic [7:0] PGA_MIN = 8'ha5;
   localparam logic [7:0] PGA_MAX = 8'hff;
   localparam logic [6:0] ATTEN_MAX = 7'h5a;
   localparam logic [3:0] ALC_TARGET_CAP = 4'hd;
   localparam logic [3:0] CODE_SATURATE = 4'ha;

   // Timing
   localparam int CLK_NS = 40;
   localparam int LIM_STEPS = 12;
   localparam int ALC_STEPS = 81;
   localparam int LIM_ATK_NS = 250000;
   localparam int ALC_ATK_NS = 8400000;
   localparam int LIM_DCY_NS = 1200000;
   localparam int ALC_DCY_NS = 33600000;
   localparam int WIN_BASE_NS = 62500;
   localparam int LIM_ATK_CYC = LIM_ATK_NS / CLK_NS / LIM_STEPS;
   localparam int ALC_ATK_CYC = ALC_ATK_NS / CLK_NS / ALC_STEPS;
   localparam int LIM_DCY_CYC = LIM_DCY_NS / CLK_NS / LIM_STEPS;
   localparam int ALC_DCY_CYC = ALC_DCY_NS / CLK_NS / ALC_STEPS;
   localparam int WIN_BASE_CYC = (WIN_BASE_NS + CLK_NS - 1) / CLK_NS;

   // Linear peak thresholds, -16 dBFS .. -1 dBFS, 24-bit full scale
   localparam logic [23:0] THRESH_TABLE [16] = '{
      24'h144968, 24'h16c329, 24'h198a58, 24'h1ca7ce,
      24'h2026ff, 24'h241350, 24'h287a00, 24'h2d6a59,
      24'h32f538, 24'h392ccc, 24'h4026ea, 24'h47faea,
      24'h50c345, 24'h5a9e08, 24'h65ac85, 24'h721499
   };

endpackage : alc_pkg

// ### core/alc_step_timer.sv
/*
 * Interval timer giving a one-cycle tick every INTERVAL clocks while
 * run is high. Assumes interval is at least one.
 */
`timescale 1ns/10ps
module alc_step_timer #(
   parameter int W = 24
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Control
   input wire logic run,
   input wire logic [W-1:0] interval,
   // Result
   output logic tick
);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic tick;
   } alc_timer_st_t;

   alc_timer_st_t st_reg;
   alc_timer_st_t st_next;

   always_comb begin
      st_next = st_reg;
      st_next.tick = 1'b0;
      if (!run) begin
         st_next.cnt = '0;
      end else if (st_reg.cnt >= interval - W'(1)) begin
         st_next.cnt = '0;
         st_next.tick = 1'b1;
      end else begin
         st_next.cnt = st_reg.cnt + W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tick = st_reg.tick;

endmodule : alc_step_timer

// ### sim/alc_gain_limiter_assertions.sv
/*
 * Port-level checker for the PGA gain control loop.
 * Assumes control bits change only through reg_wr; it keeps its own
 * copy of enable, zero-cross and function select.
 */
`timescale 1ns/10ps
module alc_gain_limiter_assertions (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Register port
   input wire logic reg_wr,
   input wire logic [6:0] reg_addr,
   input wire logic [8:0] reg_wdata,
   input wire logic [8:0] reg_rdata,
   // Samples and gains
   input wire logic sample_valid,
   input wire logic [23:0] sample_right,
   input wire logic [7:0] static_gain_left,
   input wire logic [7:0] static_gain_right,
   input wire logic [7:0] pga_gain_left,
   input wire logic [7:0] pga_gain_right
);
   logic en_q;
   logic zc_q;
   logic sgn_q;
   logic [1:0] fn_q;
   logic [1:0] cnt_q;
   logic zx;
   logic cfg_wr;
   logic settled;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   assign cfg_wr = reg_wr && (reg_addr == alc_pkg::ADDR_CONFIG_ONE ||
      reg_addr == alc_pkg::ADDR_CONFIG_TWO);
   // Mode changes take two edges to reach the gains; wait three
   assign settled = (cnt_q == 2'h3);
   assign zx = sample_valid && (sample_right[23] != sgn_q);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         en_q <= 1'b0;
         zc_q <= 1'b0;
         fn_q <= 2'h0;
         cnt_q <= 2'h0;
         sgn_q <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == alc_pkg::ADDR_CONFIG_TWO) begin
            en_q <= reg_wdata[8];
            zc_q <= reg_wdata[7];
         end
         if (reg_wr && reg_addr == alc_pkg::ADDR_CONFIG_ONE) begin
            fn_q <= reg_wdata[8:7];
         end
         cnt_q <= cfg_wr ? 2'h0 : ((cnt_q == 2'h3) ? cnt_q : cnt_q + 2'h1);
         if (sample_valid) begin
            sgn_q <= sample_right[23];
         end
      end
   end

   sequence s_move;
      pga_gain_right != $past(pga_gain_right);
   endsequence
   sequence s_rest;
      pga_gain_right == $past(pga_gain_right);
   endsequence

   AST_OFF_L: assert property (settled && !en_q
      |-> pga_gain_left == $past(static_gain_left))
      else $error("left gain differs from static while off");
   AST_OFF_R: assert property (settled && !en_q
      |-> pga_gain_right == $past(static_gain_right))
      else $error("right gain differs from static while off");
   AST_LIM_CEIL: assert property (settled && en_q && fn_q == 2'h0
      |-> pga_gain_left <= $past(static_gain_left) &&
          pga_gain_right <= $past(static_gain_right))
      else $error("limiter raised gain above static");
   // A channel sitting on the PGA floor may lag the other one
   AST_LIM_PAIR: assert property (settled && en_q && fn_q == 2'h0
      && pga_gain_left > alc_pkg::PGA_MIN &&
      pga_gain_right > alc_pkg::PGA_MIN
      |-> 8'($past(static_gain_left) - pga_gain_left) ==
          8'($past(static_gain_right) - pga_gain_right))
      else $error("limiter attenuation differs between channels");
   AST_RIGHT_ONLY: assert property (settled && en_q && fn_q == 2'h1
      |-> pga_gain_left == $past(static_gain_left))
      else $error("left gain moved in right-only mode");
   AST_LEFT_ONLY: assert property (settled && en_q && fn_q == 2'h2
      |-> pga_gain_right == $past(static_gain_right))
      else $error("right gain moved in left-only mode");
   AST_ONE_CODE: assert property (settled && en_q && !zc_q
      |-> 8'($past(pga_gain_right) - pga_gain_right) inside
          {8'h00, 8'h01, 8'hff})
      else $error("gain moved by more than one code");
   AST_STEP_GAP: assert property (settled && en_q && !zc_q ##0 s_move
      |=> s_rest)
      else $error("gain steps on consecutive clocks");
   AST_ZC_ONLY: assert property (settled && en_q && zc_q && fn_q == 2'h1
      ##0 s_move |-> $past(zx) || $past(zx, 2) || $past(zx, 3) ||
      $past(zx, 4))
      else $error("gain changed away from a zero crossing");
   // Static codes below the PGA range pass through the limiter untouched
   AST_FLOOR: assert property (settled && en_q
      && $past(static_gain_left) >= alc_pkg::PGA_MIN &&
      $past(static_gain_right) >= alc_pkg::PGA_MIN
      |-> pga_gain_left >= alc_pkg::PGA_MIN &&
          pga_gain_right >= alc_pkg::PGA_MIN)
      else $error("gain below bottom of range");
endmodule : alc_gain_limiter_assertions

bind alc_gain_limiter alc_gain_limiter_assertions u_chk (
   .clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .sample_valid(sample_valid), .sample_right(sample_right),
   .static_gain_left(static_gain_left),
   .static_gain_right(static_gain_right),
   .pga_gain_left(pga_gain_left), .pga_gain_right(pga_gain_right));

// ### sim/alc_gain_limiter_tb.sv
/*
 * Self-checking bench for the PGA gain control loop.
 * Assumes short step bases so that code-0 limiter ramps last tens of clocks.
 */
`timescale 1ns/10ps
module alc_gain_limiter_tb;
   localparam int LA = 4;
   localparam int LD = 6;
   localparam int WB = 8;
   localparam logic [23:0] BIG = 24'h7fffff;
   localparam logic [23:0] MID = 24'h680000;
   localparam logic [23:0] LOW = 24'h010000;
   typedef struct {
      logic [6:0] a;
      logic [8:0] w;
      logic [8:0] r;
      bit mp;
   } alc_row_t;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic reg_wr = 1'b0;
   logic [6:0] reg_addr = 7'h00;
   logic [8:0] reg_wdata = 9'h000;
   logic [8:0] reg_rdata;
   logic sample_valid = 1'b0;
   logic [23:0] sample_left = 24'h000000;
   logic [23:0] sample_right = 24'h000000;
   logic [7:0] static_gain_left = 8'hc0;
   logic [7:0] static_gain_right = 8'hd8;
   logic [7:0] pga_gain_left;
   logic [7:0] pga_gain_right;
   logic [8:0] a1;
   int failures = 0;
   int n_checks = 0;
   alc_row_t rows [6] = '{
      '{alc_pkg::ADDR_CONFIG_ONE, 9'h1a5, alc_pkg::RST_CONFIG_ONE, 1'b1},
      '{alc_pkg::ADDR_CONFIG_TWO, 9'h07f, alc_pkg::RST_CONFIG_TWO, 1'b1},
      '{alc_pkg::ADDR_RAMP_TIMES, 9'h1c3, alc_pkg::RST_RAMP_TIMES, 1'b1},
      '{alc_pkg::ADDR_WINDOW_CFG, 9'h155, alc_pkg::RST_WINDOW_CFG, 1'b1},
      '{7'h13, 9'h1ff, 9'h000, 1'b0},
      '{7'h7f, 9'h1ff, 9'h000, 1'b0}
   };

   alc_gain_limiter #(.LIM_ATK_BASE(LA), .ALC_ATK_BASE(LA),
      .LIM_DCY_BASE(LD), .ALC_DCY_BASE(LD), .WIN_BASE(WB)) uut (
      .clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .sample_valid(sample_valid), .sample_left(sample_left),
      .sample_right(sample_right), .static_gain_left(static_gain_left),
      .static_gain_right(static_gain_right),
      .pga_gain_left(pga_gain_left), .pga_gain_right(pga_gain_right));

   always #20 clk = ~clk;

   task automatic stop_test;
      if (failures == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test

   task automatic chk(string nm, logic [8:0] exp, logic [8:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic chk_in(string nm, logic [8:0] lo, logic [8:0] hi,
      logic [8:0] got);
      n_checks++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         failures++;
         $display("BAD %s expected %h..%h seen %h", nm, lo, hi, got);
      end
   endtask : chk_in

   task automatic wr(logic [6:0] a, logic [8:0] d);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask : wr

   task automatic rd(logic [6:0] a, string nm, logic [8:0] exp);
      @(negedge clk);
      reg_addr = a;
      repeat (2) @(negedge clk);
      chk(nm, exp, reg_rdata);
   endtask : rd

   // Samples flow every clock so the peak flag never goes stale
   task automatic drive(int n, logic [23:0] l, logic [23:0] r, bit alt);
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         sample_left = (alt && i[0]) ? -l : l;
         sample_right = (alt && i[0]) ? -r : r;
      end
   endtask : drive

   function automatic logic [8:0] att(bit rgt);
      return rgt ? {1'b0, static_gain_right} - {1'b0, pga_gain_right}
         : {1'b0, static_gain_left} - {1'b0, pga_gain_left};
   endfunction : att

   task automatic mode(logic [8:0] one, logic [8:0] two);
      wr(alc_pkg::ADDR_CONFIG_TWO, 9'h000);
      wr(alc_pkg::ADDR_CONFIG_ONE, one);
      wr(alc_pkg::ADDR_CONFIG_TWO, two);
   endtask : mode

   initial begin
      #(40 * 20000);
      failures++;
      stop_test();
   end

   initial begin
      repeat (6) @(negedge clk);
      rst_b = 1'b1;
      sample_valid = 1'b1;
      repeat (2) @(negedge clk);
      chk("pass_r", {1'b0, static_gain_right}, {1'b0, pga_gain_right});
      static_gain_right = 8'hd0;
      repeat (2) @(negedge clk);
      chk("pass_r", {1'b0, static_gain_right}, {1'b0, pga_gain_right});
      foreach (rows[i]) begin
         rd(rows[i].a, "reset", rows[i].r);
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, "readback", rows[i].mp ? rows[i].w : 9'h000);
      end
      chk("off_l", 9'h000, att(1'b0));
      // Limiter, no window, fastest ramps
      wr(alc_pkg::ADDR_WINDOW_CFG, 9'h000);
      wr(alc_pkg::ADDR_RAMP_TIMES, 9'h000);
      mode(9'h07f, 9'h100);
      drive(60, MID, MID, 1'b0);
      chk("lim_top", 9'h000, att(1'b1));
      wr(alc_pkg::ADDR_CONFIG_ONE, 9'h07b);
      drive(40, BIG, LOW, 1'b0);
      a1 = att(1'b0);
      chk_in("lim_atk", 9'd8, 9'd10, a1);
      chk("lim_pair", a1, att(1'b1));
      drive(30, LOW, LOW, 1'b0);
      chk_in("lim_dcy", 9'd3, 9'd6, a1 - att(1'b0));
      drive(300, LOW, LOW, 1'b0);
      chk("lim_back", 9'h000, att(1'b0));
      // Window of 32 clocks hides a 20-clock burst
      wr(alc_pkg::ADDR_WINDOW_CFG, 9'h030);
      drive(20, BIG, LOW, 1'b0);
      drive(10, LOW, LOW, 1'b0);
      chk("win_hide", 9'h000, att(1'b0));
      drive(70, BIG, LOW, 1'b0);
      chk_in("win_pass", 9'd5, 9'd10, att(1'b0));
      drive(300, LOW, LOW, 1'b0);
      // Attack code 11 must act as code 10
      wr(alc_pkg::ADDR_WINDOW_CFG, 9'h000);
      wr(alc_pkg::ADDR_RAMP_TIMES, 9'h00b);
      drive(4150, BIG, LOW, 1'b0);
      chk("atk_sat", 9'd1, att(1'b0));
      wr(alc_pkg::ADDR_RAMP_TIMES, 9'h000);
      // Level control on right, left and both
      for (int i = 1; i < 4; i++) begin
         mode({i[1:0], 7'h7f}, 9'h100);
         drive(80, MID, MID, 1'b0);
         chk("alc_l", {8'h00, i[1]},
            {8'h00, pga_gain_left < static_gain_left});
         chk("alc_r", {8'h00, i[0]},
            {8'h00, pga_gain_right < static_gain_right});
      end
      drive(200, LOW, LOW, 1'b0);
      chk("alc_up", 9'h001,
         {8'h00, pga_gain_left > static_gain_left});
      // Zero-cross gating on right-only level control
      mode(9'h0ff, 9'h180);
      drive(80, MID, MID, 1'b0);
      chk("zc_hold", 9'h000, att(1'b1));
      drive(80, MID, MID, 1'b1);
      chk("zc_move", 9'h001,
         {8'h00, pga_gain_right < static_gain_right});
      // Mid-run reset drops the loop and restores the defaults
      rst_b = 1'b0;
      @(negedge clk);
      chk("rst_r", {1'b0, alc_pkg::PGA_MIN}, {1'b0, pga_gain_right});
      @(negedge clk);
      rst_b = 1'b1;
      rd(alc_pkg::ADDR_CONFIG_TWO, "rst_two", alc_pkg::RST_CONFIG_TWO);
      rd(alc_pkg::ADDR_WINDOW_CFG, "rst_win", alc_pkg::RST_WINDOW_CFG);
      chk("rst_off", {1'b0, static_gain_right}, {1'b0, pga_gain_right});
      stop_test();
   end
endmodule : alc_gain_limiter_tb
